// ==== src/sfp_pkg.sv ====
package sfp_pkg;

   // ------------------------------------------------------------
   // clock and times
   // ------------------------------------------------------------
   localparam int  CLK_MHZ           = 125;
   localparam real OV_FILTER_US      = 6.5;
   localparam real SHORT_SENSE_US    = 60.0;
   localparam real REFRESH_MS        = 14.0;
   localparam real ON_OPEN_SENSE_MS  = 12.0;
   localparam real OFF_OPEN_SENSE_US = 60.0;
   localparam real LOW_PIN_DELAY_US  = 60.0;
   localparam real BLANK_US          = 2.0;

   localparam int OV_FILTER_CYC      = int'($ceil(OV_FILTER_US * CLK_MHZ));
   localparam int SHORT_SENSE_CYC    = int'($ceil(SHORT_SENSE_US * CLK_MHZ));
   localparam int REFRESH_CYC        = int'($ceil(REFRESH_MS * 1000.0 * CLK_MHZ));
   localparam int ON_OPEN_SENSE_CYC  = int'($ceil(ON_OPEN_SENSE_MS * 1000.0 * CLK_MHZ));
   localparam int OFF_OPEN_SENSE_CYC = int'($ceil(OFF_OPEN_SENSE_US * CLK_MHZ));
   localparam int LOW_PIN_DELAY_CYC  = int'($ceil(LOW_PIN_DELAY_US * CLK_MHZ));
   localparam int BLANK_CYC          = int'($ceil(BLANK_US * CLK_MHZ));

   localparam int TMR_W    = 21;
   localparam int CUR_W    = 10;
   localparam int DITHER_W = 10;
   localparam int NCH      = 2;

   // command code just under 50 mA with a one-ohm sense resistor
   localparam logic [CUR_W-1:0] CUR_50MA = 10'h033;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int           ADR_W       = 4;
   localparam logic [3:0]   CH0_CFG_OFS = 4'h0;
   localparam logic [3:0]   CH1_CFG_OFS = 4'h4;
   localparam logic [3:0]   FAULT_OFS   = 4'h8;
   localparam logic [3:0]   STATUS_OFS  = 4'hc;

   localparam int CFG_TYPING_POS = 10;
   localparam int FLT_OC_POS     = 0;
   localparam int FLT_OG_POS     = 1;
   localparam int FLT_CH_STRIDE  = 2;
   localparam int ST_OV_POS      = 0;
   localparam int ST_GATE_POS    = 1;
   localparam int ST_REF_POS     = 3;
   localparam int ST_DITHER_POS  = 16;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic             typing;
      logic [CUR_W-1:0] current;
   } sfp_cfg_t;

   typedef struct packed {
      logic gate_req;
      logic pos_over;
      logic pos_low;
      logic neg_low;
   } sfp_sense_t;

   typedef enum logic [3:0] {
      ST_OFF     = 4'h1,
      ST_BLANK   = 4'h2,
      ST_ON      = 4'h4,
      ST_REFRESH = 4'h8
   } sfp_state_t;

   localparam sfp_cfg_t CFG_RST = '0;

endpackage

// ==== src/sfp_filt.sv ====
`timescale 1ns/1ps
module sfp_filt #(
   parameter int WIDTH = 21,
   parameter int LIMIT = 8
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic cond,
   output logic      expired
);

   logic [WIDTH-1:0] cnt;
   wire              at_limit = (cnt == WIDTH'(LIMIT - 1));

   // ------------------------------------------------------------
   // filter counter
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt     <= '0;
         expired <= 1'b0;
      end else if (!cond) begin
         cnt     <= '0;
         expired <= 1'b0;
      end else begin
         expired <= expired | at_limit;
         if (!at_limit && !expired) begin
            cnt <= cnt + 1'b1;
         end
      end
   end

endmodule

// ==== src/sfp_prot.sv ====
`timescale 1ns/1ps
// What this block does
// - battery overvoltage filtered about 6.5 us, then outputs forced off
// - bus keeps working during overvoltage; outputs resume when comparator drops
// - overvoltage leaves registers alone; dither counter keeps running
// - overvoltage switches both channels off together
// - overcurrent checked only with gate on; 60 us above threshold turns driver off
// - overcurrent fault bit latched until fault register is read
// - after overcurrent, off for 14 ms refresh, then automatic retry
// - overcurrent check blanked after every off-to-on gate transition
// - commands during refresh are stored, applied once refresh ends
// - overcurrent detection, latch and refresh kept per channel
// - no overcurrent fault when command is below 50 mA
// - command above 50 mA, gate on past 12 ms sets open/ground fault
// - command above 50 mA, gate off, low pin low past 60 us sets fault
// - low command, typing clear: high pin low or low-pin condition sets fault
// - low command, typing set: same high-pin and low-pin detection applies
// - typing set enables high-pin pull-up, cleared enables pull-down
// - typing bit never changes gate state or load current
// - short to ground still reported with zero commanded current
// - safe-state input resets registers but keeps fault bits
// - reset clears faults and returns registers to defaults
module sfp_prot #(
   parameter int SHORT_SENSE_CYC    = sfp_pkg::SHORT_SENSE_CYC,
   parameter int REFRESH_CYC        = sfp_pkg::REFRESH_CYC,
   parameter int ON_OPEN_SENSE_CYC  = sfp_pkg::ON_OPEN_SENSE_CYC,
   parameter int OFF_OPEN_SENSE_CYC = sfp_pkg::OFF_OPEN_SENSE_CYC,
   parameter int LOW_PIN_DELAY_CYC  = sfp_pkg::LOW_PIN_DELAY_CYC
) (
   input  wire logic                                CLK,
   input  wire logic                                RESETN,
   input  wire logic                                CYC_I,
   input  wire logic                                STB_I,
   input  wire logic                                WE_I,
   input  wire logic [sfp_pkg::ADR_W-1:0]           ADR_I,
   input  wire logic [3:0]                          SEL_I,
   input  wire logic [31:0]                         DAT_I,
   output logic      [31:0]                         DAT_O,
   output logic                                     ACK_O,
   input  wire logic                                BATTERY_SUPPLY_PIN_OVER,
   input  wire logic                                SAFE_STATE,
   input  wire sfp_pkg::sfp_sense_t [sfp_pkg::NCH-1:0] SENSE,
   output logic      [sfp_pkg::NCH-1:0]             GATE_ON,
   output logic      [sfp_pkg::NCH-1:0]             PULL_UP,
   output logic      [sfp_pkg::NCH-1:0]             PULL_DOWN,
   output logic                                     OV_ACTIVE,
   output logic      [sfp_pkg::DITHER_W-1:0]        DITHER_CNT
);

   localparam int NCH = sfp_pkg::NCH;
   localparam int TW  = sfp_pkg::TMR_W;

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic sfp_pkg::sfp_cfg_t apply_wr(input sfp_pkg::sfp_cfg_t old,
                                                  input logic [31:0]         data,
                                                  input logic [3:0]          sel);
      sfp_pkg::sfp_cfg_t res;
      res = old;
      if (sel[0]) begin
         res.current[7:0] = data[7:0];
      end
      if (sel[1]) begin
         res.current[9:8] = data[9:8];
         res.typing       = data[sfp_pkg::CFG_TYPING_POS];
      end
      return res;
   endfunction

   function automatic logic above_50ma(input sfp_pkg::sfp_cfg_t cfg);
      return cfg.current > sfp_pkg::CUR_50MA;
   endfunction

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic                            ack;
   sfp_pkg::sfp_cfg_t [NCH-1:0]     cfg_reg;
   sfp_pkg::sfp_cfg_t [NCH-1:0]     act_cfg;
   logic [NCH-1:0]                  oc_fault;
   logic [NCH-1:0]                  og_fault;
   logic [NCH-1:0]                  in_refresh;
   logic [NCH-1:0]                  gate;
   logic                            ov_active;
   logic [sfp_pkg::DITHER_W-1:0]    dither;

   wire        bus_req   = CYC_I & STB_I & ~ack;
   wire        wr_en     = bus_req & WE_I & ~SAFE_STATE;
   wire        rd_en     = bus_req & ~WE_I;
   wire        sel_cfg0  = (ADR_I == sfp_pkg::CH0_CFG_OFS);
   wire        sel_cfg1  = (ADR_I == sfp_pkg::CH1_CFG_OFS);
   wire        sel_fault = (ADR_I == sfp_pkg::FAULT_OFS);
   wire        sel_stat  = (ADR_I == sfp_pkg::STATUS_OFS);
   wire        fault_clr = rd_en & sel_fault & ~SAFE_STATE;

   wire [31:0] fault_word;
   wire [31:0] stat_word;
   wire [31:0] rd_data;

   assign fault_word = {28'h0000000, og_fault[1], oc_fault[1], og_fault[0], oc_fault[0]};
   assign stat_word  = {6'h00, dither, 11'h000, in_refresh, gate, ov_active};
   assign rd_data    = sel_cfg0  ? {21'h000000, cfg_reg[0]} :
                       sel_cfg1  ? {21'h000000, cfg_reg[1]} :
                       sel_fault ? fault_word :
                       sel_stat  ? stat_word  : 32'h00000000;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack   <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ack   <= bus_req;
         DAT_O <= rd_en ? rd_data : 32'h00000000;
      end
   end

   assign ACK_O = ack;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   wire [NCH-1:0] wr_cfg = {wr_en & sel_cfg1, wr_en & sel_cfg0};

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_reg <= {NCH{sfp_pkg::CFG_RST}};
      end else if (SAFE_STATE) begin
         cfg_reg <= {NCH{sfp_pkg::CFG_RST}};
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_cfg[i]) begin
               cfg_reg[i] <= apply_wr(cfg_reg[i], DAT_I, SEL_I);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // overvoltage and dither
   // ------------------------------------------------------------
   logic ov_expired;

   sfp_filt #(
      .WIDTH (TW),
      .LIMIT (sfp_pkg::OV_FILTER_CYC)
   ) u_ov_filt (
      .clk     (CLK),
      .resetn  (RESETN),
      .cond    (BATTERY_SUPPLY_PIN_OVER),
      .expired (ov_expired)
   );

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ov_active <= 1'b0;
         dither    <= '0;
      end else begin
         ov_active <= ov_expired;
         dither    <= dither + 1'b1;
      end
   end

   assign OV_ACTIVE  = ov_active;
   assign DITHER_CNT = dither;

   // ------------------------------------------------------------
   // per-channel protection
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      sfp_pkg::sfp_state_t state;
      sfp_pkg::sfp_state_t next_state;
      logic [TW-1:0]       tmr;
      logic [TW-1:0]       next_tmr;
      logic                oc_exp;
      logic                on_open_exp;
      logic                low_pin_exp;
      logic                pos_low_exp;

      wire high_cmd = above_50ma(act_cfg[ch]);
      wire drive    = SENSE[ch].gate_req & (act_cfg[ch].current != '0) & ~ov_active;
      wire tmr_done = (tmr == '0);
      wire gate_now = (state == sfp_pkg::ST_BLANK) | (state == sfp_pkg::ST_ON);

      wire oc_cond  = (state == sfp_pkg::ST_ON) & SENSE[ch].pos_over & high_cmd;
      wire on_cond  = gate_now & high_cmd;
      wire neg_cond = ~gate_now & SENSE[ch].neg_low;
      // high pin low at low command
      // same check for either typing value
      wire pos_cond = ~high_cmd & SENSE[ch].pos_low;
      // stored command waits out the refresh
      wire hold_cfg = (next_state == sfp_pkg::ST_REFRESH);

      // ------------------------------------------------------------
      // channel filters
      // ------------------------------------------------------------
      // restartable filters
      sfp_filt #(.WIDTH(TW), .LIMIT(SHORT_SENSE_CYC)) u_oc (
         .clk     (CLK),
         .resetn  (RESETN),
         .cond    (oc_cond),
         .expired (oc_exp)
      );

      sfp_filt #(.WIDTH(TW), .LIMIT(ON_OPEN_SENSE_CYC)) u_on_open (
         .clk     (CLK),
         .resetn  (RESETN),
         .cond    (on_cond),
         .expired (on_open_exp)
      );

      sfp_filt #(.WIDTH(TW), .LIMIT(LOW_PIN_DELAY_CYC)) u_low_pin (
         .clk     (CLK),
         .resetn  (RESETN),
         .cond    (neg_cond),
         .expired (low_pin_exp)
      );

      sfp_filt #(.WIDTH(TW), .LIMIT(OFF_OPEN_SENSE_CYC)) u_pos_low (
         .clk     (CLK),
         .resetn  (RESETN),
         .cond    (pos_cond),
         .expired (pos_low_exp)
      );

      // ------------------------------------------------------------
      // channel state machine
      // ------------------------------------------------------------
      always_comb begin
         next_state = state;
         next_tmr   = tmr;
         case (state)
            sfp_pkg::ST_OFF: begin
               if (drive) begin
                  next_state = sfp_pkg::ST_BLANK;
                  next_tmr   = TW'(sfp_pkg::BLANK_CYC - 1);
               end
            end
            sfp_pkg::ST_BLANK: begin
               if (!drive) begin
                  next_state = sfp_pkg::ST_OFF;
               end else if (tmr_done) begin
                  next_state = sfp_pkg::ST_ON;
               end else begin
                  next_tmr = tmr - 1'b1;
               end
            end
            sfp_pkg::ST_ON: begin
               if (oc_exp) begin
                  next_state = sfp_pkg::ST_REFRESH;
                  next_tmr   = TW'(REFRESH_CYC - 1);
               end else if (!drive) begin
                  next_state = sfp_pkg::ST_OFF;
               end
            end
            sfp_pkg::ST_REFRESH: begin
               if (tmr_done) begin
                  next_state = sfp_pkg::ST_OFF;
               end else begin
                  next_tmr = tmr - 1'b1;
               end
            end
            default: begin
               next_state = sfp_pkg::ST_OFF;
               next_tmr   = '0;
            end
         endcase
      end

      always_ff @(posedge CLK or negedge RESETN) begin
         if (!RESETN) begin
            state <= sfp_pkg::ST_OFF;
            tmr   <= '0;
         end else begin
            state <= next_state;
            tmr   <= next_tmr;
         end
      end

      always_ff @(posedge CLK or negedge RESETN) begin
         if (!RESETN) begin
            act_cfg[ch] <= sfp_pkg::CFG_RST;
         end else if (SAFE_STATE) begin
            act_cfg[ch] <= sfp_pkg::CFG_RST;
         end else if (!hold_cfg) begin
            act_cfg[ch] <= cfg_reg[ch];
         end
      end

      // ------------------------------------------------------------
      // fault latches
      // ------------------------------------------------------------
      always_ff @(posedge CLK or negedge RESETN) begin
         if (!RESETN) begin
            oc_fault[ch] <= 1'b0;
            og_fault[ch] <= 1'b0;
         end else begin
            oc_fault[ch] <= oc_exp | (oc_fault[ch] & ~fault_clr);
            og_fault[ch] <= on_open_exp | low_pin_exp | pos_low_exp | (og_fault[ch] & ~fault_clr);
         end
      end

      // ------------------------------------------------------------
      // channel outputs
      // ------------------------------------------------------------
      always_ff @(posedge CLK or negedge RESETN) begin
         if (!RESETN) begin
            gate[ch]       <= 1'b0;
            in_refresh[ch] <= 1'b0;
            PULL_UP[ch]    <= 1'b0;
            PULL_DOWN[ch]  <= 1'b1;
         end else begin
            gate[ch]       <= (next_state == sfp_pkg::ST_BLANK) | (next_state == sfp_pkg::ST_ON);
            in_refresh[ch] <= (next_state == sfp_pkg::ST_REFRESH);
            PULL_UP[ch]    <= cfg_reg[ch].typing;
            PULL_DOWN[ch]  <= ~cfg_reg[ch].typing;
         end
      end
   end

   assign GATE_ON = gate;

endmodule

// ==== verif/sfp_prot_chk.sv ====
`timescale 1ns/1ps
module sfp_prot_chk (
   input wire logic                          CLK,
   input wire logic                          RESETN,
   input wire logic                          CYC_I,
   input wire logic                          STB_I,
   input wire logic                          WE_I,
   input wire logic [31:0]                   DAT_O,
   input wire logic                          ACK_O,
   input wire logic                          BATTERY_SUPPLY_PIN_OVER,
   input wire logic                          SAFE_STATE,
   input wire logic [sfp_pkg::NCH-1:0]       GATE_ON,
   input wire logic [sfp_pkg::NCH-1:0]       PULL_UP,
   input wire logic [sfp_pkg::NCH-1:0]       PULL_DOWN,
   input wire logic                          OV_ACTIVE,
   input wire logic [sfp_pkg::DITHER_W-1:0]  DITHER_CNT
);
   // ------------------------------------------------------------
   // overvoltage run length
   // ------------------------------------------------------------
   logic [10:0] ov_run;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ov_run <= '0;
      end else if (!BATTERY_SUPPLY_PIN_OVER) begin
         ov_run <= '0;
      end else if (ov_run != 11'h7ff) begin
         ov_run <= ov_run + 11'h001;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_req_taken;
      CYC_I && STB_I && !ACK_O;
   endsequence
   sequence s_ov_held;
      OV_ACTIVE ##1 OV_ACTIVE;
   endsequence
   a_ack_follows: assert property (s_req_taken |=> ACK_O) else $error("ack missing after request");
   a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
   a_dat_quiet: assert property (!(ACK_O && !WE_I) |-> DAT_O == 32'h0) else $error("read data outside read ack");
   a_ov_filter: assert property ($rose(OV_ACTIVE) |-> ov_run >= 11'd800 && ov_run <= 11'd830)
      else $error("overvoltage filter length wrong");
   a_ov_release: assert property ($fell(BATTERY_SUPPLY_PIN_OVER) |-> ##[0:3] !OV_ACTIVE)
      else $error("overvoltage not released");
   a_ov_both_off: assert property (s_ov_held |-> GATE_ON == '0) else $error("gate on in overvoltage");
   a_dither_runs: assert property ($past(RESETN) |-> DITHER_CNT == $past(DITHER_CNT) + 10'h001)
      else $error("dither counter stalled");
   a_pull_select: assert property (PULL_UP == ~PULL_DOWN) else $error("pull selection wrong");
   a_pull_hold: assert property ($changed(PULL_UP) |-> $past(ACK_O && WE_I) || $past(SAFE_STATE, 2))
      else $error("pull changed without write");
   a_safe_off: assert property (SAFE_STATE [*3] |-> GATE_ON == '0) else $error("gate on in safe state");
endmodule
bind sfp_prot sfp_prot_chk u_chk (.CLK(CLK), .RESETN(RESETN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
   .DAT_O(DAT_O), .ACK_O(ACK_O), .BATTERY_SUPPLY_PIN_OVER(BATTERY_SUPPLY_PIN_OVER), .SAFE_STATE(SAFE_STATE),
   .GATE_ON(GATE_ON), .PULL_UP(PULL_UP), .PULL_DOWN(PULL_DOWN), .OV_ACTIVE(OV_ACTIVE), .DITHER_CNT(DITHER_CNT));

// ==== verif/sfp_load.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// load model: mode 0 normal, 1 short to battery, 2 open, 3 short to ground
// ------------------------------------------------------------
module sfp_load (
   input wire logic                    clk,
   input wire logic                    resetn,
   input wire logic [1:0]              gate_on,
   input wire logic [1:0]              pull_up,
   input wire logic [3:0]              mode,
   output sfp_pkg::sfp_sense_t [1:0]   sense
);
   logic [4:0] phase;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase <= '0;
      end else begin
         phase <= phase + 5'h01;
      end
   end
   for (genvar i = 0; i < 2; i++) begin : g_ch
      wire [1:0] md  = mode[2*i +: 2];
      wire       req = (md == 2'h0) ? phase[4] : 1'b1;
      assign sense[i] = {req, (md == 2'h1) && gate_on[i], (md == 2'h3) || ((md == 2'h2) && !pull_up[i]),
                         (md == 2'h3) && !gate_on[i]};
   end
endmodule

// ==== verif/test_sfp_prot.sv ====
`timescale 1ns/1ps
module test_sfp_prot;
   logic                     clk;
   logic                     resetn;
   logic                     cyc;
   logic                     stb;
   logic                     we;
   logic [3:0]               adr;
   logic [3:0]               sel;
   logic [31:0]              dat_w;
   logic [31:0]              dat_r;
   logic                     ack;
   logic                     bat_over;
   logic                     safe;
   sfp_pkg::sfp_sense_t [1:0] sense;
   logic [1:0]               gate_on;
   logic [1:0]               pull_up;
   logic [1:0]               pull_down;
   logic                     ov_active;
   logic [9:0]               dither;
   logic [3:0]               mode;
   int                       err_total;
   int                       compares;
   int                       ticks;

   sfp_prot #(.SHORT_SENSE_CYC(20), .REFRESH_CYC(50), .ON_OPEN_SENSE_CYC(40), .OFF_OPEN_SENSE_CYC(15),
      .LOW_PIN_DELAY_CYC(15)) uut (.CLK(clk), .RESETN(resetn), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .BATTERY_SUPPLY_PIN_OVER(bat_over),
      .SAFE_STATE(safe), .SENSE(sense), .GATE_ON(gate_on), .PULL_UP(pull_up), .PULL_DOWN(pull_down),
      .OV_ACTIVE(ov_active), .DITHER_CNT(dither));
   sfp_load load (.clk(clk), .resetn(resetn), .gate_on(gate_on), .pull_up(pull_up), .mode(mode), .sense(sense));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_rst;
      logic [31:0] q;
      wb(1'b0, sfp_pkg::CH0_CFG_OFS, 32'h0, q);
      cmp("cfg_reset", 32'h0, q);
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      cmp("fault_reset", 32'h0, q & 32'hf);
      wb(1'b0, 4'h2, 32'h0, q);
      cmp("unmapped_read", 32'h0, q);
      cmp("pull_reset", 32'h3, {30'h0, pull_down});
   endtask
   task automatic t_oc;
      logic [31:0] q;
      int n;
      mode <= 4'h1;
      wb(1'b1, sfp_pkg::CH1_CFG_OFS, 32'h100, q);
      wb(1'b1, sfp_pkg::CH0_CFG_OFS, 32'h100, q);
      while (gate_on[0] !== 1'b1) @(posedge clk);
      n = 0;
      while (gate_on[0] === 1'b1) begin
         @(posedge clk);
         n++;
      end
      cmp("oc_on_time", 32'h1, {31'h0, n >= 268 && n <= 278});
      n = 0;
      while (gate_on[0] !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      cmp("refresh_time", 32'h1, {31'h0, n >= 50 && n <= 56});
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      cmp("fault_oc", 32'h3, q & 32'h7);
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      cmp("fault_clear", 32'h0, q & 32'h5);
      while (gate_on[0] === 1'b1) @(posedge clk);
      wb(1'b1, sfp_pkg::CH0_CFG_OFS, 32'h0, q);
      wb(1'b0, sfp_pkg::STATUS_OFS, 32'h0, q);
      cmp("refresh_status", 32'h8, q & 32'h1a);
      n = 0;
      repeat (200) begin
         @(posedge clk);
         n += int'(gate_on[0] !== 1'b0);
      end
      cmp("stored_cmd", 32'h0, n);
      wb(1'b0, sfp_pkg::CH0_CFG_OFS, 32'h0, q);
      cmp("stored_cfg", 32'h0, q);
   endtask
   task automatic t_low;
      logic [31:0] q;
      wb(1'b1, sfp_pkg::CH0_CFG_OFS, 32'h033, q);
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      repeat (400) @(posedge clk);
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      cmp("oc_low_cmd", 32'h0, q & 32'h1);
      mode <= 4'h0;
   endtask
   task automatic t_ov;
      logic [31:0] q;
      logic seen;
      int n;
      seen = 1'b0;
      wb(1'b1, sfp_pkg::CH0_CFG_OFS, 32'h100, q);
      bat_over <= 1'b1;
      repeat (400) begin
         @(posedge clk);
         seen |= ov_active;
      end
      bat_over <= 1'b0;
      cmp("ov_spike", 32'h0, {31'h0, seen});
      repeat (2) @(posedge clk);
      bat_over <= 1'b1;
      repeat (900) @(posedge clk);
      cmp("ov_active", 32'h1, {31'h0, ov_active});
      cmp("ov_gates", 32'h0, {30'h0, gate_on});
      wb(1'b0, sfp_pkg::STATUS_OFS, 32'h0, q);
      cmp("ov_status", 32'h1, q & 32'h1);
      wb(1'b0, sfp_pkg::CH1_CFG_OFS, 32'h0, q);
      cmp("ov_regs_kept", 32'h100, q);
      bat_over <= 1'b0;
      repeat (4) @(posedge clk);
      cmp("ov_release", 32'h0, {31'h0, ov_active});
      n = 0;
      while (gate_on[0] !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      cmp("ov_resume", 32'h1, {31'h0, n < 400});
   endtask
   task automatic t_typ;
      logic [31:0] q;
      for (int md = 2; md < 4; md++) begin
         mode <= 4'(md << 2);
         wb(1'b1, sfp_pkg::CH1_CFG_OFS, 32'h0, q);
         repeat (30) @(posedge clk);
         wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
         cmp("og_typing_clear", 32'h8, q & 32'h8);
         repeat (3) wb(1'b1, sfp_pkg::CH1_CFG_OFS, 32'h400, q);
         cmp("pull_up", 32'h1, {31'h0, pull_up[1]});
         wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
         repeat (30) @(posedge clk);
         wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
         cmp("og_typing_set", (md == 3) ? 32'h8 : 32'h0, q & 32'h8);
      end
   endtask
   task automatic t_safe;
      logic [31:0] q;
      repeat (30) @(posedge clk);
      mode <= 4'h0;
      repeat (5) @(posedge clk);
      safe <= 1'b1;
      repeat (5) @(posedge clk);
      safe <= 1'b0;
      repeat (2) @(posedge clk);
      wb(1'b0, sfp_pkg::FAULT_OFS, 32'h0, q);
      cmp("safe_fault_kept", 32'h8, q & 32'h8);
      wb(1'b0, sfp_pkg::CH1_CFG_OFS, 32'h0, q);
      cmp("safe_cfg_reset", 32'h0, q);
      cmp("safe_pull", 32'h1, {31'h0, pull_down[1]});
   endtask
   // ------------------------------------------------------------
   // clock, timeout, main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      ticks++;
      if (ticks == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      resetn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'hf;
      dat_w = 32'h0;
      bat_over = 1'b0;
      safe = 1'b0;
      mode = 4'h0;
      err_total = 0;
      compares = 0;
      ticks = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_rst();
      t_oc();
      t_low();
      t_ov();
      t_typ();
      t_safe();
      complete_run();
   end
endmodule
